// ### include/add_exec_pkg.sv
/*
 * Shared constants and carriers for the add-instruction execute block.
 * Assumes a single core clock and a data memory with one-cycle read latency.
 */
package add_exec_pkg;
    // ==========================================================
    // Instruction encodings
    localparam logic [5:0] ADD_FILE_TOP = 6'h09;
    localparam logic [7:0] ADD_LIT_TOP  = 8'h0f;
    localparam int         D_BIT       = 9;
    localparam int         A_BIT       = 8;
    // ==========================================================
    // Addressing
    localparam logic [7:0] INDEX_LIMIT = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;
    // ==========================================================
    // Reset values
    localparam logic [7:0] WREG_RESET  = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [3:0] BANK_RESET  = 4'h0;
    localparam logic [11:0] INDEX_RESET = 12'h000;

    typedef enum logic [1:0] {
        Q1 = 2'b00,
        Q2 = 2'b01,
        Q3 = 2'b10,
        Q4 = 2'b11
    } phase_e;

    typedef struct packed {
        logic negative;
        logic overflow_flag;
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } flags_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } mem_req_s;
endpackage

// ### hw/add_instruction_execute.sv
/*
 * Decode and execute for the literal-add and register-add instructions.
 * Assumes data memory answers a read on MEM_RDATA one cycle after the request,
 * and that a new instruction word is offered only while INSTR_READY is high.
 */
// Behaviour
// - Register-add (001001 d a f) adds accumulator to file register and updates all five flags.
// - Destination bit clear writes the sum to the accumulator only.
// - Destination bit set writes the sum back to the file register.
// - Bank bit clear resolves the address in the access bank.
// - Bank bit set forms the address from bank_pointer and file address.
// - Extended set, bank bit clear, f up to 5Fh is an indexed literal offset.
// - One word, one cycle of four phases: decode, read, process, write.
// - Literal-add (0000 1111 k) adds literal to accumulator in one cycle.
`timescale 1ns/10ps
module add_instruction_execute (
    input  wire logic                  CLK_SYS,
    input  wire logic                  RESETN,
    input  wire logic                  INSTR_VALID,
    input  wire logic [15:0]           INSTR_WORD,
    input  wire logic                  EXT_SET_EN,
    input  wire logic [3:0]            BANK_POINTER,
    input  wire logic [11:0]           INDEX_BASE,
    input  wire logic [7:0]            MEM_RDATA,
    output logic                       INSTR_READY,
    output logic                       INSTR_DONE,
    output logic                       INSTR_ILLEGAL,
    output add_exec_pkg::mem_req_s     MEM_REQ,
    output logic [7:0]                 WREG,
    output add_exec_pkg::flags_s       FLAGS
);
    // ==========================================================
    // State
    add_exec_pkg::phase_e   phase_q,   phase_d;
    logic                   busy_q,    busy_d;
    logic                   is_lit_q,  is_lit_d;
    logic                   dest_q,    dest_d;
    logic [7:0]             opnd_q,    opnd_d;
    logic [7:0]             sum_q,     sum_d;
    logic [7:0]             wreg_q,    wreg_d;
    add_exec_pkg::flags_s   flags_q,   flags_d;
    add_exec_pkg::mem_req_s req_q,     req_d;
    logic                   done_q,    done_d;
    logic                   ill_q,     ill_d;
    logic                   ready_q,   ready_d;
    logic [8:0]             full_sum;
    logic [4:0]             low_sum;
    logic [7:0]             ovf_a;
    logic [11:0]            eff_addr;
    logic                   dec_wf;
    logic                   dec_lw;

    assign dec_wf = INSTR_WORD[15:10] == add_exec_pkg::ADD_FILE_TOP;
    assign dec_lw = INSTR_WORD[15:8] == add_exec_pkg::ADD_LIT_TOP;

    // ==========================================================
    // Address resolution
    always_comb begin
        if (INSTR_WORD[add_exec_pkg::A_BIT]) begin
            eff_addr = {BANK_POINTER, INSTR_WORD[7:0]};
        end else if (EXT_SET_EN && INSTR_WORD[7:0] <= add_exec_pkg::INDEX_LIMIT) begin
            eff_addr = INDEX_BASE + {4'h0, INSTR_WORD[7:0]};
        end else if (INSTR_WORD[7:0] < add_exec_pkg::ACCESS_SPLIT) begin
            eff_addr = {add_exec_pkg::ACCESS_LOW_BANK, INSTR_WORD[7:0]};
        end else begin
            eff_addr = {add_exec_pkg::ACCESS_HIGH_BANK, INSTR_WORD[7:0]};
        end
    end

    // ==========================================================
    // Adder; carry comes from the 8-bit add, digit carry from a separate add of the low nibbles
    assign full_sum = {1'b0, wreg_q} + {1'b0, opnd_q};
    assign low_sum  = {1'b0, wreg_q[3:0]} + {1'b0, opnd_q[3:0]};
    assign ovf_a    = wreg_q;

    // ==========================================================
    // Phase sequencer: Q1 decode, Q2 read, Q3 process, Q4 write
    always_comb begin
        phase_d  = phase_q;
        busy_d   = busy_q;
        is_lit_d = is_lit_q;
        dest_d   = dest_q;
        opnd_d   = opnd_q;
        sum_d    = sum_q;
        wreg_d   = wreg_q;
        flags_d  = flags_q;
        req_d    = '{wr: 1'b0, rd: 1'b0, addr: req_q.addr, wdata: req_q.wdata};
        done_d   = 1'b0;
        ill_d    = 1'b0;
        unique case (phase_q)
            add_exec_pkg::Q1: begin
                if (INSTR_VALID && ready_q) begin
                    if (dec_wf || dec_lw) begin
                        busy_d   = 1'b1;
                        is_lit_d = dec_lw;
                        dest_d   = INSTR_WORD[add_exec_pkg::D_BIT];
                        opnd_d   = INSTR_WORD[7:0];
                        req_d.rd   = dec_wf;
                        req_d.addr = eff_addr;
                        phase_d  = add_exec_pkg::Q2;
                    end else begin
                        ill_d = 1'b1;
                    end
                end
            end
            add_exec_pkg::Q2: begin
                if (!is_lit_q) begin
                    opnd_d = MEM_RDATA;
                end
                phase_d = add_exec_pkg::Q3;
            end
            add_exec_pkg::Q3: begin
                sum_d = full_sum[7:0];
                flags_d.carry            = full_sum[8];
                flags_d.digit_carry_flag = low_sum[4];
                flags_d.zero             = full_sum[7:0] == 8'h00;
                flags_d.negative         = full_sum[7];
                flags_d.overflow_flag    = (ovf_a[7] == opnd_q[7]) && (full_sum[7] != ovf_a[7]);
                phase_d = add_exec_pkg::Q4;
            end
            add_exec_pkg::Q4: begin
                if (!is_lit_q && dest_q) begin
                    req_d.wr    = 1'b1;
                    req_d.wdata = sum_q;
                end else begin
                    wreg_d = sum_q;
                end
                done_d  = 1'b1;
                busy_d  = 1'b0;
                phase_d = add_exec_pkg::Q1;
            end
        endcase
        ready_d = phase_d == add_exec_pkg::Q1 && !busy_d;
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            phase_q  <= add_exec_pkg::Q1;
            busy_q   <= 1'b0;
            is_lit_q <= 1'b0;
            dest_q   <= 1'b0;
            opnd_q   <= 8'h00;
            sum_q    <= 8'h00;
            wreg_q   <= add_exec_pkg::WREG_RESET;
            flags_q  <= add_exec_pkg::FLAGS_RESET;
            req_q    <= '{wr: 1'b0, rd: 1'b0, addr: add_exec_pkg::INDEX_RESET, wdata: 8'h00};
            done_q   <= 1'b0;
            ill_q    <= 1'b0;
        end else begin
            phase_q  <= phase_d;
            busy_q   <= busy_d;
            is_lit_q <= is_lit_d;
            dest_q   <= dest_d;
            opnd_q   <= opnd_d;
            sum_q    <= sum_d;
            wreg_q   <= wreg_d;
            flags_q  <= flags_d;
            req_q    <= req_d;
            done_q   <= done_d;
            ill_q    <= ill_d;
        end
    end

    // Ready is registered so it lines up with Q1; it rises one edge after reset, so no word is taken earlier
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
        end
    end

    assign INSTR_READY   = ready_q;
    assign INSTR_DONE    = done_q;
    assign INSTR_ILLEGAL = ill_q;
    assign MEM_REQ       = req_q;
    assign WREG          = wreg_q;
    assign FLAGS         = flags_q;

    // ==========================================================
    // Checks
    cycle_length_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (phase_q == add_exec_pkg::Q1 && phase_d == add_exec_pkg::Q2) |-> ##4 done_q)
        else $error("Instruction did not finish in four phases");
    file_read_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (phase_q == add_exec_pkg::Q1 && INSTR_VALID && ready_q && dec_wf) |=> MEM_REQ.rd)
        else $error("Register-add did not read the file register");
    lit_no_mem_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (phase_q == add_exec_pkg::Q1 && INSTR_VALID && ready_q && dec_lw) |=> ##3 (!MEM_REQ.wr && !MEM_REQ.rd))
        else $error("Literal-add touched data memory");
    wreg_dest_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (done_q && !$past(is_lit_q) && !$past(dest_q)) |-> (!MEM_REQ.wr && wreg_q == $past(sum_q)))
        else $error("Destination clear did not write the accumulator");
    file_dest_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (done_q && !$past(is_lit_q) && $past(dest_q)) |-> (MEM_REQ.wr && $stable(wreg_q)))
        else $error("Destination set did not write the file register");
    bank_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (phase_q == add_exec_pkg::Q1 && INSTR_VALID && ready_q && dec_wf && INSTR_WORD[add_exec_pkg::A_BIT])
        |=> MEM_REQ.addr == {$past(BANK_POINTER), $past(INSTR_WORD[7:0])})
        else $error("Banked address wrong");
    access_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (phase_q == add_exec_pkg::Q1 && INSTR_VALID && ready_q && dec_wf && !INSTR_WORD[add_exec_pkg::A_BIT]
         && (!EXT_SET_EN || INSTR_WORD[7:0] > add_exec_pkg::INDEX_LIMIT))
        |=> MEM_REQ.addr == {(($past(INSTR_WORD[7:0]) < add_exec_pkg::ACCESS_SPLIT) ? add_exec_pkg::ACCESS_LOW_BANK
                              : add_exec_pkg::ACCESS_HIGH_BANK), $past(INSTR_WORD[7:0])})
        else $error("Access bank address wrong");
    index_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (phase_q == add_exec_pkg::Q1 && INSTR_VALID && ready_q && dec_wf && !INSTR_WORD[add_exec_pkg::A_BIT]
         && EXT_SET_EN && INSTR_WORD[7:0] <= add_exec_pkg::INDEX_LIMIT)
        |=> MEM_REQ.addr == $past(INDEX_BASE) + {4'h0, $past(INSTR_WORD[7:0])})
        else $error("Indexed address wrong");
    zero_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        done_q |-> FLAGS.zero == ($past(sum_q) == 8'h00))
        else $error("Zero flag wrong");
    sign_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        done_q |-> FLAGS.negative == $past(sum_q[7]))
        else $error("Negative flag wrong");
    lit_wreg_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (phase_q == add_exec_pkg::Q1 && INSTR_VALID && ready_q && dec_lw)
        |=> ##3 (WREG == $past(wreg_q, 4) + $past(INSTR_WORD[7:0], 4)))
        else $error("Literal-add sum not in the accumulator");
    illegal_word_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (phase_q == add_exec_pkg::Q1 && INSTR_VALID && ready_q && !dec_wf && !dec_lw)
        |=> (INSTR_ILLEGAL && !MEM_REQ.rd && INSTR_READY && $stable(wreg_q)))
        else $error("Unknown word was not refused");
    ready_low_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (phase_q != add_exec_pkg::Q1) |-> !INSTR_READY)
        else $error("Ready raised during an instruction");
endmodule

// ### verification/add_instruction_execute_tb.sv
/*
 * Self-checking bench for the add-instruction execute block.
 * Assumes the bench plays program and data memory itself.
 */
`timescale 1ns/10ps
module add_instruction_execute_tb;
    // ==========================================================
    // Stimulus and observed signals
    logic                  CLK_SYS;
    logic                  RESETN;
    logic                  INSTR_VALID;
    logic [15:0]           INSTR_WORD;
    logic                  EXT_SET_EN;
    logic [3:0]            BANK_POINTER;
    logic [11:0]           INDEX_BASE;
    logic [7:0]            MEM_RDATA;
    logic                  INSTR_READY;
    logic                  INSTR_DONE;
    logic                  INSTR_ILLEGAL;
    add_exec_pkg::mem_req_s MEM_REQ;
    logic [7:0]            WREG;
    add_exec_pkg::flags_s  FLAGS;
    int                    errors;
    int                    checked;
    logic [7:0]            w_exp;
    logic [3:0]            rd_h;
    logic [3:0]            wr_h;
    logic [3:0]            dn_h;
    logic                  ill_seen;

    add_instruction_execute add_instruction_execute_inst (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
        .INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD), .EXT_SET_EN(EXT_SET_EN),
        .BANK_POINTER(BANK_POINTER), .INDEX_BASE(INDEX_BASE), .MEM_RDATA(MEM_RDATA),
        .INSTR_READY(INSTR_READY), .INSTR_DONE(INSTR_DONE), .INSTR_ILLEGAL(INSTR_ILLEGAL),
        .MEM_REQ(MEM_REQ), .WREG(WREG), .FLAGS(FLAGS));

    // ==========================================================
    // Helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic add_exec_pkg::flags_s flg(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        add_exec_pkg::flags_s f;
        s = a + b;
        f.negative = s[7];
        f.overflow_flag = (a[7] == b[7]) && (s[7] != a[7]);
        f.zero = (s[7:0] == 8'h00);
        f.digit_carry_flag = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
        f.carry = s[8];
        return f;
    endfunction

    // Offers one word, memory answers rv once, then shows junk so a late sample is caught
    // Outputs are recorded at the falling edge of each of the four cycles after the take
    task automatic offer(input logic [15:0] w, input logic [7:0] rv, input logic [11:0] ea);
        int n;
        n = 0;
        ill_seen = 1'b0;
        while (INSTR_READY !== 1'b1 && n < 20) begin
            @(negedge CLK_SYS);
            n++;
        end
        check("ready", INSTR_READY, 1);
        @(posedge CLK_SYS);
        INSTR_VALID <= 1'b1;
        INSTR_WORD  <= w;
        MEM_RDATA   <= rv;
        @(posedge CLK_SYS);
        INSTR_VALID <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(negedge CLK_SYS);
            rd_h[i] = MEM_REQ.rd;
            wr_h[i] = MEM_REQ.wr;
            dn_h[i] = INSTR_DONE;
            if (INSTR_ILLEGAL === 1'b1) ill_seen = 1'b1;
            if (i == 0 && MEM_REQ.rd === 1'b1) check("rd addr", MEM_REQ.addr, ea);
            if (i == 3 && MEM_REQ.wr === 1'b1) check("wr addr", MEM_REQ.addr, ea);
            if (i == 0) begin
                @(posedge CLK_SYS);
                MEM_RDATA <= ~rv;
            end
        end
    endtask

    // Runs one add and judges timing, destination, address and flags
    task automatic exec(input logic [15:0] w, input logic [7:0] rv, input logic [11:0] ea);
        logic       lit;
        logic [7:0] b;
        logic [7:0] s;
        lit = (w[15:8] == add_exec_pkg::ADD_LIT_TOP);
        b = lit ? w[7:0] : rv;
        s = w_exp + b;
        offer(w, rv, ea);
        check("rd timing", rd_h, lit ? 4'h0 : 4'h1);
        check("done timing", dn_h, 4'h8);
        check("write back", wr_h, (!lit && w[9]) ? 4'h8 : 4'h0);
        if (!lit && w[9]) check("wdata", MEM_REQ.wdata, s);
        check("flags", FLAGS, flg(w_exp, b));
        check("illegal", ill_seen, 0);
        if (lit || !w[9]) w_exp = s;
        check("wreg", WREG, w_exp);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_literal();
        exec(16'h0f10, 8'h00, 12'h000);
        exec(16'h0f15, 8'h00, 12'h000);
        exec(16'h0f5b, 8'h00, 12'h000);
        exec(16'h0f80, 8'h00, 12'h000);
        $display("literal add done");
    endtask

    task automatic t_access();
        exec(16'h0f17, 8'h00, 12'h000);
        @(posedge CLK_SYS);
        BANK_POINTER <= 4'h7;
        exec(16'h24c2, 8'hc2, 12'hfc2);
        exec(16'h2410, 8'h0e, 12'h010);
        exec(16'h265f, 8'h33, 12'h05f);
        $display("access bank done");
    endtask

    task automatic t_banked();
        @(posedge CLK_SYS);
        BANK_POINTER <= 4'h5;
        exec(16'h2710, 8'hf0, 12'h510);
        exec(16'h25ff, 8'h01, 12'h5ff);
        $display("banked done");
    endtask

    task automatic t_indexed();
        @(posedge CLK_SYS);
        EXT_SET_EN <= 1'b1;
        INDEX_BASE <= 12'h100;
        exec(16'h245f, 8'h11, 12'h15f);
        exec(16'h2400, 8'h22, 12'h100);
        exec(16'h2660, 8'h44, 12'hf60);
        exec(16'h2520, 8'h08, 12'h520);
        @(posedge CLK_SYS);
        EXT_SET_EN <= 1'b0;
        $display("indexed done");
    endtask

    task automatic t_illegal();
        offer(16'h2000, 8'h55, 12'h000);
        check("illegal pulse", ill_seen, 1);
        check("no read", rd_h, 4'h0);
        check("no done", dn_h, 4'h0);
        check("wreg kept", WREG, w_exp);
        $display("illegal done");
    endtask

    // ==========================================================
    // Clock, reset, run
    task automatic wrap_up();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        CLK_SYS = 1'b0;
        forever #10 CLK_SYS = ~CLK_SYS;
    end

    // Whole run is well under 400 cycles; the margin covers a stalled handshake
    initial begin
        #(20 * 3000);
        errors++;
        wrap_up();
    end

    initial begin
        errors = 0;
        checked = 0;
        w_exp = add_exec_pkg::WREG_RESET;
        RESETN = 1'b0;
        INSTR_VALID = 1'b0;
        INSTR_WORD = 16'h0000;
        EXT_SET_EN = 1'b0;
        BANK_POINTER = 4'h0;
        INDEX_BASE = 12'h000;
        MEM_RDATA = 8'h00;
        repeat (6) @(posedge CLK_SYS);
        RESETN <= 1'b1;
        t_literal();
        t_access();
        t_banked();
        t_indexed();
        t_illegal();
        wrap_up();
    end
endmodule
